// >>> core/rpa_lane_align.sv
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - a reverse burst starts only while the lane has been turned around and reverse mode is granted.
// - the clock lane stays the master's; this end only samples it and drives nothing but data.
// - one reverse bit is launched every four link-clock edges, i.e. every two clock periods.
// - the launch phase is chosen at burst start and held fixed until the burst ends.
// - every reverse burst opens with the sync pattern, the only alignment aid.
// - the receiver picks its sampling slot from where the sync pattern shows up.
// - sampling follows the link clock's own edges, so bit-interval jitter and loop delay do not matter.
// - the clock source may change only while both directions are idle, flagged on lp_ok_o.
// - above 1.5 Gbps a burst waits for static-skew calibration to be done.
// - slot numbering puts rising edges on even slots so a bit period starts on a rising edge when its launch or sampling slot is even.
module rpa_lane_align (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic lclk_i,
  input wire logic rev_mode_i,
  input wire logic hi_rate_i,
  input wire logic cal_done_i,
  input wire logic tx_req_i,
  input wire logic [1:0] tx_phase_i,
  input wire logic in_valid_i,
  input wire logic in_data_i,
  output logic in_ready_o,
  output logic lane_data_o,
  output logic lane_oe_o,
  input wire logic lane_data_i,
  input wire logic lane_active_i,
  output var rpa_pkg::rpa_rx_word_t rx_o,
  output logic lp_ok_o
);

  rpa_pkg::rpa_state_t s;
  rpa_pkg::rpa_state_t next_s;
  logic edge_seen;
  logic rise;
  logic [1:0] next_slot;
  logic launch;
  logic pop;
  logic push;
  logic start;
  logic sync_bit;
  logic [1:0] wpos;

  function automatic logic [2:0] sync_match(input logic [3:0][7:0] h);
    logic [2:0] r;
    r = 3'h0;
    for (int p = 3; p >= 0; p--) begin
      if (h[p] == rpa_pkg::SYNC_PATTERN) begin
        r = {1'b1, 2'(p)};
      end
    end
    return r;
  endfunction

  always_comb begin
    logic [2:0] m;
    m = 3'h0;
    next_s = s;
    // first sync stage feeds only the second
    next_s.lclk_sync = {s.lclk_sync[0], lclk_i};
    next_s.din_sync = {s.din_sync[0], lane_data_i};
    next_s.act_sync = {s.act_sync[0], lane_active_i};
    next_s.lclk_prev = s.lclk_sync[1];
    edge_seen = s.lclk_sync[1] ^ s.lclk_prev;
    rise = s.lclk_sync[1] & ~s.lclk_prev;
    // upper bit follows the edge count, lower bit is forced by the edge direction
    next_slot = {s.slot[1] ^ s.slot[0], ~rise};
    if (edge_seen) begin
      next_s.slot = next_slot;
    end
    start = (s.tx_st == rpa_pkg::TX_IDLE) && tx_req_i && rev_mode_i
      && (!hi_rate_i || cal_done_i);
    launch = edge_seen && (next_slot == s.tx_phase);
    sync_bit = rpa_pkg::SYNC_PATTERN[3'(4'h7 - s.tx_cnt)];
    pop = 1'b0;
    unique case (s.tx_st)
      rpa_pkg::TX_IDLE: begin
        if (start) begin
          next_s.tx_phase = tx_phase_i;
          next_s.tx_cnt = 4'h0;
          // lane starts low so the leading sync bit is a clean step
          next_s.tx_bit = 1'b0;
          next_s.tx_drive = 1'b1;
          next_s.tx_st = rpa_pkg::TX_SYNC;
        end
      end
      rpa_pkg::TX_SYNC: begin
        if (launch) begin
          next_s.tx_bit = sync_bit;
          next_s.tx_cnt = s.tx_cnt + 4'h1;
          if (s.tx_cnt == rpa_pkg::SYNC_LEN - 4'h1) begin
            next_s.tx_st = rpa_pkg::TX_DATA;
          end
        end
      end
      rpa_pkg::TX_DATA: begin
        if (launch) begin
          if (s.buf_cnt != 2'h0) begin
            pop = 1'b1;
            next_s.tx_bit = s.buf_data[0];
          end else if (!tx_req_i) begin
            // burst ends on a bit boundary, never mid-bit
            next_s.tx_drive = 1'b0;
            next_s.tx_st = rpa_pkg::TX_IDLE;
          end
        end
      end
      default: begin
        next_s.tx_st = rpa_pkg::TX_IDLE;
        next_s.tx_drive = 1'b0;
      end
    endcase
    push = in_valid_i && s.in_ready;
    if (pop) begin
      next_s.buf_data[0] = s.buf_data[1];
    end
    wpos = s.buf_cnt - {1'b0, pop};
    if (push) begin
      next_s.buf_data[wpos[0]] = in_data_i;
    end
    next_s.buf_cnt = s.buf_cnt + {1'b0, push} - {1'b0, pop};
    next_s.in_ready = (next_s.buf_cnt != rpa_pkg::BUF_DEPTH);
    // receive side: one history per slot, compared against sync
    next_s.rx.valid = 1'b0;
    if (edge_seen && s.act_sync[1]) begin
      next_s.hist[next_slot] = {s.hist[next_slot][6:0], s.din_sync[1]};
      if (s.rx_lock) begin
        if (next_slot == s.rx.phase) begin
          next_s.rx.valid = 1'b1;
          next_s.rx.data = s.din_sync[1];
        end
      end else begin
        m = sync_match(next_s.hist);
        if (m[2]) begin
          next_s.rx_lock = 1'b1;
          next_s.rx.phase = m[1:0];
        end
      end
    end
    if (!s.act_sync[1]) begin
      next_s.rx_lock = 1'b0;
      next_s.hist = '0;
    end
    next_s.lp_ok = (next_s.tx_st == rpa_pkg::TX_IDLE) && !next_s.rx_lock
      && !s.act_sync[1];
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s <= '0;
      s.slot <= rpa_pkg::SLOT_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign in_ready_o = s.in_ready;
  assign lane_data_o = s.tx_bit;
  assign lane_oe_o = s.tx_drive;
  assign rx_o = s.rx;
  assign lp_ok_o = s.lp_ok;

  // helper: link-clock edges since the last launch
  logic [2:0] edge_cnt;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      edge_cnt <= 3'h0;
    end else if (launch) begin
      edge_cnt <= 3'h0;
    end else if (edge_seen && edge_cnt != 3'h7) begin
      edge_cnt <= edge_cnt + 3'h1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  chk_bit_spacing: assert property (
    (launch && s.tx_st != rpa_pkg::TX_IDLE && s.tx_cnt != 4'h0)
      |-> edge_cnt == rpa_pkg::EDGES_PER_BIT - 3'h1)
    else $error("reverse bit launched off the four-edge spacing");
  chk_phase_hold: assert property (
    (s.tx_st != rpa_pkg::TX_IDLE && $past(s.tx_st) != rpa_pkg::TX_IDLE) |-> $stable(s.tx_phase))
    else $error("launch phase changed inside a burst");
  chk_sync_first: assert property (
    (launch && s.tx_st == rpa_pkg::TX_SYNC) |=> lane_data_o == $past(sync_bit))
    else $error("sync pattern bit wrong");
  chk_enter_turn: assert property (
    $rose(lane_oe_o) |-> $past(rev_mode_i) && $past(tx_req_i))
    else $error("burst started without turnaround");
  chk_cal_gate: assert property (
    ($rose(lane_oe_o) && $past(hi_rate_i)) |-> $past(cal_done_i))
    else $error("high-rate burst before calibration");
  chk_rise_even: assert property (
    (edge_seen && rise) |=> !s.slot[0])
    else $error("rising edge on an odd slot");
  chk_rx_slot: assert property (
    rx_o.valid |-> s.rx_lock && s.slot == rx_o.phase)
    else $error("reverse bit taken off the locked slot");
  chk_lock_hold: assert property (
    (s.rx_lock && $past(s.rx_lock)) |-> $stable(rx_o.phase))
    else $error("sampling slot moved while locked");
  chk_lock_clear: assert property (
    !s.act_sync[1] |=> !s.rx_lock ##1 !rx_o.valid)
    else $error("lock not cleared at burst end");
  chk_lp_gate: assert property (
    lp_ok_o |-> !lane_oe_o && !s.rx_lock)
    else $error("idle flagged during a burst");
  chk_buf_ready: assert property (
    in_ready_o |-> s.buf_cnt != rpa_pkg::BUF_DEPTH)
    else $error("ready while buffer full");

  cov_lock: cover property ($rose(s.rx_lock));
  cov_burst_end: cover property ($fell(lane_oe_o));
  cov_buf_full: cover property (s.buf_cnt == rpa_pkg::BUF_DEPTH);
  cov_phase3: cover property ($rose(lane_oe_o) && s.tx_phase == 2'h3);

endmodule // rpa_lane_align

`default_nettype wire

// >>> common/rpa_pkg.sv
package rpa_pkg;

  // burst-start pattern, sent first, most significant bit first
  localparam logic [7:0] SYNC_PATTERN = 8'hb8;
  localparam logic [3:0] SYNC_LEN = 4'h8;
  // link-clock edges per reverse bit: two full periods
  localparam logic [2:0] EDGES_PER_BIT = 3'h4;
  localparam logic [1:0] SLOT_RESET = 2'h3;
  localparam logic [1:0] BUF_DEPTH = 2'h2;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SYNC = 2'b01,
    TX_DATA = 2'b10
  } rpa_tx_state_t;

  typedef struct packed {
    logic valid;
    logic data;
    logic [1:0] phase;
  } rpa_rx_word_t;

  typedef struct packed {
    rpa_tx_state_t tx_st;
    logic [1:0] tx_phase;
    logic [3:0] tx_cnt;
    logic tx_drive;
    logic tx_bit;
    logic [1:0] buf_data;
    logic [1:0] buf_cnt;
    logic in_ready;
    logic [1:0] lclk_sync;
    logic lclk_prev;
    logic [1:0] din_sync;
    logic [1:0] act_sync;
    logic [1:0] slot;
    logic [3:0][7:0] hist;
    logic rx_lock;
    rpa_rx_word_t rx;
    logic lp_ok;
  } rpa_state_t;

endpackage

// >>> verification/rpa_remote_lane.sv
`timescale 1ns/1ps
`default_nettype none
module rpa_remote_lane (
  output logic lclk_o,
  output logic lane_data_o,
  output logic lane_active_o
);
  initial begin
    lclk_o = 1'b0;
    lane_data_o = 1'b0;
    lane_active_o = 1'b0;
  end
  // clock runs only inside a call; data moves mid-way between edges
  task automatic run(input logic act, input int n, input logic [31:0] bits, input int h);
    lane_active_o = act;
    for (int i = n - 1; i >= 0; i--) begin
      lane_data_o = act ? bits[i] : ~lane_data_o;
      #(h / 2) lclk_o = 1'b1;
      #h lclk_o = 1'b0;
      #h lclk_o = 1'b1;
      #h lclk_o = 1'b0;
      #(h / 2);
    end
    lane_active_o = 1'b0;
    lane_data_o = ~lane_data_o;
  endtask
endmodule // rpa_remote_lane
`default_nettype wire

// >>> verification/rpa_lane_align_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module rpa_lane_align_tb_top;
  logic clk_i, srst_i, rev_mode_i, hi_rate_i, cal_done_i, tx_req_i, in_valid_i, in_data_i;
  logic [1:0] tx_phase_i;
  logic in_ready_o, lane_data_o, lane_oe_o, lclk_i, lane_data_i, lane_active_i, lp_ok_o;
  rpa_pkg::rpa_rx_word_t rx_o;
  int num_errors = 0;
  int checks = 0;
  rpa_remote_lane u_far (.lclk_o(lclk_i), .lane_data_o(lane_data_i), .lane_active_o(lane_active_i));
  rpa_lane_align u_dut (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .lclk_i(lclk_i),
    .rev_mode_i(rev_mode_i),
    .hi_rate_i(hi_rate_i),
    .cal_done_i(cal_done_i),
    .tx_req_i(tx_req_i),
    .tx_phase_i(tx_phase_i),
    .in_valid_i(in_valid_i),
    .in_data_i(in_data_i),
    .in_ready_o(in_ready_o),
    .lane_data_o(lane_data_o),
    .lane_oe_o(lane_oe_o),
    .lane_data_i(lane_data_i),
    .lane_active_i(lane_active_i),
    .rx_o(rx_o),
    .lp_ok_o(lp_ok_o)
  );
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // outputs are read 1 ns after the edge so the design's updates have landed
  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask
  // on_oe picks the output enable, otherwise the data lane drive
  task automatic wait_for(input string what, input bit on_oe, input logic lvl, input int lim);
    int n = 0;
    while ((on_oe ? lane_oe_o : lane_data_o) !== lvl) begin
      tick();
      n++;
      if (n > lim) begin
        chk(what, 16'h1, 16'h0);
        conclude();
      end
    end
  endtask
  task automatic t_reset();
    repeat (6) tick();
    chk("oe in reset", lane_oe_o, 1'b0);
    srst_i <= 1'b0;
    repeat (3) tick();
    chk("lp ok idle", lp_ok_o, 1'b1);
    $display("reset test done");
  endtask
  task automatic t_refuse();
    tx_req_i <= 1'b1;
    repeat (20) tick();
    chk("oe no turnaround", lane_oe_o, 1'b0);
    rev_mode_i <= 1'b1;
    hi_rate_i <= 1'b1;
    repeat (20) tick();
    chk("oe uncalibrated", lane_oe_o, 1'b0);
    tx_req_i <= 1'b0;
    cal_done_i <= 1'b1;
    tick();
    $display("refuse test done");
  endtask
  // the buffer is filled before the burst; the last payload bit then repeats
  task automatic t_tx(input logic [1:0] ph, input logic [1:0] pay);
    logic [10:0] got;
    in_valid_i <= 1'b1;
    in_data_i <= pay[1];
    tick();
    in_data_i <= pay[0];
    tick();
    in_valid_i <= 1'b0;
    tick();
    chk("ready when full", in_ready_o, 1'b0);
    tx_req_i <= 1'b1;
    tx_phase_i <= ph;
    fork
      u_far.run(1'b0, 16, 32'h0, 40);
      begin
        wait_for("launch", 1'b0, 1'b1, 400);
        chk("launch edge", lclk_i, !ph[0]);
        chk("oe in burst", lane_oe_o, 1'b1);
        repeat (16) tick();
        for (int i = 10; i >= 0; i--) begin
          got[i] = lane_data_o;
          repeat (32) tick();
        end
        chk("reverse bits", got, {8'hb8, pay, pay[0]});
        chk("ready drained", in_ready_o, 1'b1);
        tx_req_i <= 1'b0;
        wait_for("release", 1'b1, 1'b0, 200);
      end
    join
    repeat (3) tick();
    chk("lp ok after tx", lp_ok_o, 1'b1);
    $display("tx test done");
  endtask
  task automatic t_rx(input logic [7:0] pay, input int h);
    logic [7:0] got;
    logic [1:0] ph;
    int n = 0;
    fork
      u_far.run(1'b1, 17, {8'hb8, pay, 1'b0}, h);
      for (int t = 0; t < 4000 && n < 8; t++) begin
        tick();
        if (rx_o.valid === 1'b1) begin
          if (n == 0)
            ph = rx_o.phase;
          chk("slot held", rx_o.phase, ph);
          got[7 - n] = rx_o.data;
          n++;
        end
      end
    join
    chk("rx bits", got, pay);
    chk("rx count", 16'(n), 16'h8);
    chk("lock slot even", ph[0], 1'b0);
    repeat (4) tick();
    chk("lp ok after rx", lp_ok_o, 1'b1);
    $display("rx test done");
  endtask
  initial begin
    {rev_mode_i, hi_rate_i, cal_done_i, tx_req_i, tx_phase_i, in_valid_i, in_data_i} = '0;
    srst_i = 1'b1;
    t_reset();
    t_refuse();
    t_tx(2'h0, 2'b10);
    t_tx(2'h3, 2'b01);
    t_rx(8'h5a, 40);
    t_rx(8'hc3, 50);
    conclude();
  end
endmodule // rpa_lane_align_tb_top
`default_nettype wire
